/* hw/sleis_pkg.sv */
// Function
// - Sleep instruction sleeps only while sleep_allow is one.
// - sleep_depth_select zero gives idle, one gives power-down.
// - Pin b sense: 0 low level, 1 reserved, 2 falling, 3 rising.
// - Pin a sense uses the same four codes.
// - Pin request taken only with global enable and pin mask both set.
// - Pins sampled on core clock; edges found on sampled value.
// - Edge pulses longer than one clock period are always caught.
// - Enabled low level keeps requesting while the pin stays low.
// - Enabled interrupt wakes the core, handler runs, then resumes.
// - Sleep and wake leave registers, RAM and I/O contents unchanged.
// - Any reset during sleep wakes into the reset vector.
// - Idle halts CPU; timers, watchdog and interrupts keep running.
// - Wake from idle restarts execution at once.
// - Power-down stops oscillator; pin logic and enabled watchdog stay alive.
// - Power-down wakes only on reset, watchdog or low-level pin request.
// - Top two bits of the control register read zero.
// - Edge sets flag; handler entry or write-one clears; level mode holds clear.
package sleis_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [1:0] SLEIS_ADDR_CTRL = 2'h0;
  localparam logic [1:0] SLEIS_ADDR_MASK = 2'h1;
  localparam logic [1:0] SLEIS_ADDR_FLAG = 2'h2;
  localparam logic [1:0] SLEIS_ADDR_STAT = 2'h3;
  localparam int SLEIS_BIT_ALLOW = 5;
  localparam int SLEIS_BIT_DEPTH = 4;
  localparam int SLEIS_BIT_B_HI = 3;
  localparam int SLEIS_BIT_A_HI = 1;
  localparam int SLEIS_BIT_MASK_B = 7;
  localparam int SLEIS_BIT_MASK_A = 6;
  localparam logic [7:0] SLEIS_CTRL_RST = 8'h00;
  localparam logic [7:0] SLEIS_CTRL_WMASK = 8'h3F;
  localparam logic [7:0] SLEIS_MASK_WMASK = 8'hC0;

  // ****************************************
  // Sense codes and timing
  // ****************************************
  localparam logic [1:0] SLEIS_SENSE_LOW = 2'h0;
  localparam logic [1:0] SLEIS_SENSE_RSVD = 2'h1;
  localparam logic [1:0] SLEIS_SENSE_FALL = 2'h2;
  localparam logic [1:0] SLEIS_SENSE_RISE = 2'h3;
  localparam int SLEIS_CLK_MHZ = 25;
  localparam int SLEIS_TOUT_US = 16;
  localparam int SLEIS_TOUT_CYC = SLEIS_TOUT_US * SLEIS_CLK_MHZ;

  typedef enum logic [1:0] {
    SLEIS_RUN = 2'b00,
    SLEIS_IDLE = 2'b01,
    SLEIS_PDOWN = 2'b10,
    SLEIS_WAKEDLY = 2'b11
  } sleis_state_t;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sleis_bus_t;

endpackage

/* hw/sleis_sense.sv */
`timescale 1ns/10ps
// ****************************************
// Per-pin sense decode and edge flag
// ****************************************
module sleis_sense
  import sleis_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic pinSync,
  input wire logic [1:0] senseMode,
  input wire logic flagClear,
  output logic edgeFlag,
  output logic levelReq
);
  logic prev_reg;
  logic edgeHit;

  // Previous sample for edge compare
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_reg <= 1'b1;
    end else begin
      prev_reg <= pinSync;
    end
  end

  // Edge detect on sampled value; reserved code gives nothing
  always_comb begin
    case (senseMode)
      SLEIS_SENSE_FALL: edgeHit = prev_reg & ~pinSync;
      SLEIS_SENSE_RISE: edgeHit = ~prev_reg & pinSync;
      default: edgeHit = 1'b0;
    endcase
  end

  assign levelReq = (senseMode == SLEIS_SENSE_LOW) & ~pinSync;

  // Flag: set wins over clear; held clear in level modes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      edgeFlag <= 1'b0;
    end else if (!senseMode[1]) begin
      edgeFlag <= 1'b0;
    end else if (edgeHit) begin
      edgeFlag <= 1'b1;
    end else if (flagClear) begin
      edgeFlag <= 1'b0;
    end
  end

  AST_LEVEL_FLAG_CLEAR: assert property (@(posedge clk) disable iff (rst)
    !senseMode[1] |=> !edgeFlag) else $error("edge flag set in level mode");
  AST_RSVD_NO_REQ: assert property (@(posedge clk) disable iff (rst)
    senseMode == SLEIS_SENSE_RSVD |-> !levelReq && !edgeHit) else $error("reserved code made a request");
endmodule

/* hw/sleis_sync.sv */
`timescale 1ns/10ps
// ****************************************
// Two-stage pin synchroniser
// ****************************************
module sleis_sync
  import sleis_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic pinIn,
  output logic pinOut
);
  logic meta_reg;

  // Second stage is the only reader of the first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= 1'b1;
      pinOut <= 1'b1;
    end else begin
      meta_reg <= pinIn;
      pinOut <= meta_reg;
    end
  end
endmodule

/* hw/sleis_top.sv */
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
// ****************************************
// Sleep control and external pin interrupt sense
// ****************************************
module sleis_top
  import sleis_pkg::*;
#(
  parameter int TOUT_CYC = SLEIS_TOUT_CYC
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  input wire logic sleepInstr,
  input wire logic globalIrqEnable,
  input wire logic [1:0] handlerEntry,
  input wire logic extIrqPinA,
  input wire logic extIrqPinB,
  input wire logic wdogResetReq,
  input wire logic wdogEnable,
  input wire logic extResetReq,
  output logic [1:0] irqReq,
  output logic cpuHalt,
  output logic oscStop,
  output logic resetVector,
  output logic resumeNext
);
  sleis_bus_t bus;
  sleis_state_t state_reg, state_next;
  logic [7:0] ctrl_reg;
  logic [1:0] mask_reg;
  logic pinSyncA, pinSyncB;
  logic [1:0] edgeFlag, levelReq, flagClear, pending, taken;
  logic [15:0] dly_reg;
  logic anyReset, levelWake, dlyDone;

  assign bus = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

  // ****************************************
  // Pin sampling and sense
  // ****************************************
  sleis_sync u_sync_a (.clk(clk), .rst(rst), .pinIn(extIrqPinA), .pinOut(pinSyncA));
  sleis_sync u_sync_b (.clk(clk), .rst(rst), .pinIn(extIrqPinB), .pinOut(pinSyncB));

  // Write-one clear or handler entry clears the flag
  assign flagClear = handlerEntry |
    ((bus.wr && bus.addr == SLEIS_ADDR_FLAG) ? {bus.wdata[7], bus.wdata[6]} : 2'b00);

  sleis_sense u_sense_a (
    .clk(clk), .rst(rst), .pinSync(pinSyncA),
    .senseMode(ctrl_reg[SLEIS_BIT_A_HI -: 2]),
    .flagClear(flagClear[0]), .edgeFlag(edgeFlag[0]), .levelReq(levelReq[0])
  );
  sleis_sense u_sense_b (
    .clk(clk), .rst(rst), .pinSync(pinSyncB),
    .senseMode(ctrl_reg[SLEIS_BIT_B_HI -: 2]),
    .flagClear(flagClear[1]), .edgeFlag(edgeFlag[1]), .levelReq(levelReq[1])
  );

  assign pending = edgeFlag | levelReq;
  assign taken = pending & mask_reg & {2{globalIrqEnable}};
  assign anyReset = extResetReq | (wdogEnable & wdogResetReq);
  assign levelWake = |(levelReq & mask_reg & {2{globalIrqEnable}});
  assign dlyDone = (dly_reg >= 16'(TOUT_CYC - 1));

  // ****************************************
  // Registers
  // ****************************************
  // Control and mask; untouched by sleep or wake
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= SLEIS_CTRL_RST;
      mask_reg <= 2'b00;
    end else if (bus.wr) begin
      if (bus.addr == SLEIS_ADDR_CTRL) begin
        ctrl_reg <= bus.wdata & SLEIS_CTRL_WMASK;
      end
      if (bus.addr == SLEIS_ADDR_MASK) begin
        mask_reg <= {bus.wdata[SLEIS_BIT_MASK_B], bus.wdata[SLEIS_BIT_MASK_A]};
      end
    end
  end

  // Read data one cycle after strobe; zero otherwise
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdata <= 8'h00;
    end else if (bus.rd) begin
      case (bus.addr)
        SLEIS_ADDR_CTRL: regRdata <= ctrl_reg & SLEIS_CTRL_WMASK;
        SLEIS_ADDR_MASK: regRdata <= {mask_reg, 6'h00};
        SLEIS_ADDR_FLAG: regRdata <= {edgeFlag[1], edgeFlag[0], 6'h00};
        default: regRdata <= {4'h0, levelReq, state_reg};
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end

  // ****************************************
  // Sleep state machine
  // ****************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SLEIS_RUN: begin
        if (sleepInstr && ctrl_reg[SLEIS_BIT_ALLOW]) begin
          state_next = ctrl_reg[SLEIS_BIT_DEPTH] ? SLEIS_PDOWN : SLEIS_IDLE;
        end
      end
      SLEIS_IDLE: begin
        if (anyReset || |taken) begin
          state_next = SLEIS_RUN;
        end
      end
      SLEIS_PDOWN: begin
        if (anyReset) begin
          state_next = SLEIS_RUN;
        end else if (levelWake) begin
          state_next = SLEIS_WAKEDLY;
        end
      end
      SLEIS_WAKEDLY: begin
        if (anyReset) begin
          state_next = SLEIS_RUN;
        end else if (!levelWake) begin
          state_next = SLEIS_PDOWN;
        end else if (dlyDone) begin
          state_next = SLEIS_RUN;
        end
      end
      default: state_next = SLEIS_RUN;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= SLEIS_RUN;
    end else begin
      state_reg <= state_next;
    end
  end

  // Reset-delay counter while the level is held
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dly_reg <= 16'h0000;
    end else if (state_reg == SLEIS_WAKEDLY) begin
      dly_reg <= dly_reg + 16'h0001;
    end else begin
      dly_reg <= 16'h0000;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqReq <= 2'b00;
      cpuHalt <= 1'b0;
      oscStop <= 1'b0;
      resetVector <= 1'b0;
      resumeNext <= 1'b0;
    end else begin
      // Edge requests do not reach the core in power-down
      irqReq <= (state_next == SLEIS_RUN || state_next == SLEIS_IDLE) ? taken : 2'b00;
      cpuHalt <= (state_next != SLEIS_RUN);
      oscStop <= (state_next == SLEIS_PDOWN) || (state_next == SLEIS_WAKEDLY);
      resetVector <= (state_reg != SLEIS_RUN) && anyReset;
      resumeNext <= (state_reg != SLEIS_RUN) && (state_next == SLEIS_RUN) && !anyReset;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_sleep_req;
    sleepInstr && state_reg == SLEIS_RUN;
  endsequence

  AST_NO_SLEEP_WHEN_BLOCKED: assert property (@(posedge clk) disable iff (rst)
    (s_sleep_req and !ctrl_reg[SLEIS_BIT_ALLOW]) |=> !cpuHalt) else $error("slept without permit");
  AST_DEPTH_IDLE: assert property (@(posedge clk) disable iff (rst)
    (s_sleep_req and (ctrl_reg[SLEIS_BIT_ALLOW] && !ctrl_reg[SLEIS_BIT_DEPTH])) |=> cpuHalt && !oscStop)
    else $error("idle not entered");
  AST_DEPTH_PDOWN: assert property (@(posedge clk) disable iff (rst)
    (s_sleep_req and (ctrl_reg[SLEIS_BIT_ALLOW] && ctrl_reg[SLEIS_BIT_DEPTH])) |=> cpuHalt && oscStop)
    else $error("power-down not entered");
  AST_MASKED_NO_IRQ: assert property (@(posedge clk) disable iff (rst)
    !globalIrqEnable |=> irqReq == 2'b00) else $error("request without global enable");
  AST_IDLE_WAKE_NOW: assert property (@(posedge clk) disable iff (rst)
    state_reg == SLEIS_IDLE && |taken && !anyReset |=> !cpuHalt && resumeNext) else $error("idle wake delayed");
  AST_PDOWN_EDGE_NO_WAKE: assert property (@(posedge clk) disable iff (rst)
    state_reg == SLEIS_PDOWN && !levelWake && !anyReset |=> state_reg == SLEIS_PDOWN)
    else $error("power-down left without cause");
  AST_RESET_WAKE: assert property (@(posedge clk) disable iff (rst)
    state_reg != SLEIS_RUN && extResetReq |=> resetVector && !cpuHalt) else $error("reset did not wake");
  AST_RSVD_BITS_ZERO: assert property (@(posedge clk) disable iff (rst)
    bus.rd && bus.addr == SLEIS_ADDR_CTRL |=> regRdata[7:6] == 2'b00) else $error("reserved bits read one");
  AST_LEVEL_REPEAT: assert property (@(posedge clk) disable iff (rst)
    state_reg == SLEIS_RUN && state_next == SLEIS_RUN && taken[0] && levelReq[0] |=> irqReq[0])
    else $error("level request dropped");
endmodule

/* tb/sleis_pin_model.sv */
`timescale 1ns/10ps
// ****
// Far side: two pulled-up pins and the reset source
// ****
module sleis_pin_model (
  input wire logic clk,
  output logic pinA,
  output logic pinB,
  output logic extRst
);
  // Idle levels: pins pulled high, reset released
  initial begin
    pinA = 1'h1;
    pinB = 1'h1;
    extRst = 1'h0;
  end

  // Assert one source for n whole cycles, then back to idle
  task automatic lowFor(input int p, input int n);
    @(posedge clk);
    if (p == 0) pinA <= 1'h0;
    else if (p == 1) pinB <= 1'h0;
    else extRst <= 1'h1;
    repeat (n) @(posedge clk);
    pinA <= 1'h1;
    pinB <= 1'h1;
    extRst <= 1'h0;
  endtask
endmodule

/* tb/tb_sleis_top.sv */
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; $display("FAIL %0t %h %h", $time, g, e); end end
module tb_sleis_top
  import sleis_pkg::*;
;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [1:0] regAddr = 2'h0;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'h0;
  logic regRd = 1'h0;
  logic sleepInstr = 1'h0;
  logic gie = 1'h1;
  logic [1:0] hEntry = 2'h0;
  logic wdRst = 1'h0;
  logic wdEn = 1'h0;
  logic pinA, pinB, extRst, cpuHalt, oscStop, resetVector, resumeNext;
  logic [7:0] regRdata;
  logic [7:0] d;
  logic [1:0] irqReq;
  int n_fail = 0;
  int compares = 0;
  bit got;

  // ****
  // Clock, partner and design
  // ****
  always #20 clk = ~clk;

  sleis_pin_model pm (.clk(clk), .pinA(pinA), .pinB(pinB), .extRst(extRst));

  sleis_top #(.TOUT_CYC(8)) uut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sleepInstr(sleepInstr),
    .globalIrqEnable(gie), .handlerEntry(hEntry), .extIrqPinA(pinA), .extIrqPinB(pinB),
    .wdogResetReq(wdRst), .wdogEnable(wdEn), .extResetReq(extRst), .irqReq(irqReq),
    .cpuHalt(cpuHalt), .oscStop(oscStop), .resetVector(resetVector), .resumeNext(resumeNext));

  // ****
  // Bus tasks and expectations
  // ****
  task automatic wn(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'h1;
    @(posedge clk);
    regWr <= 1'h0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge clk);
    regRd <= 1'h0;
    @(negedge clk);
    v = regRdata;
  endtask

  task automatic slp();
    @(posedge clk);
    sleepInstr <= 1'h1;
    @(posedge clk);
    sleepInstr <= 1'h0;
    wn(1);
  endtask

  task automatic clr();
    @(posedge clk);
    hEntry <= 2'h3;
    @(posedge clk);
    hEntry <= 2'h0;
  endtask

  // Watch for a wake pulse: sel 0 resume, sel 1 reset vector
  task automatic waitEv(input int w, input int sel, output bit g);
    g = 0;
    repeat (w) begin
      @(negedge clk);
      if ((sel ? resetVector : resumeNext) === 1'h1) g = 1;
    end
  endtask

  // Request while the pin is held low
  function automatic logic expLow(input int c);
    return (c == 0) || (c == 2);
  endfunction

  task automatic give_verdict();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard
  initial begin
    #160000;
    n_fail++;
    give_verdict();
  end

  // ****
  // Main sequence
  // ****
  initial begin
    void'($urandom(90546));
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    rd(SLEIS_ADDR_CTRL, d);
    `CHK(d, SLEIS_CTRL_RST)
    wr(SLEIS_ADDR_CTRL, 8'hFF);
    rd(SLEIS_ADDR_CTRL, d);
    `CHK(d, 8'h3F)
    wr(SLEIS_ADDR_MASK, 8'hC0);
    rd(SLEIS_ADDR_MASK, d);
    `CHK(d, 8'hC0)
    // Every sense code on both pins
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 4; c++) begin
        wr(SLEIS_ADDR_CTRL, 8'(c << (2 * p)));
        fork
          pm.lowFor(p, 7 + $urandom % 4);
          begin wn(6); `CHK(irqReq[p], expLow(c)) end
        join
        wn(5);
        `CHK(irqReq[p], c[1])
        clr();
        wn(2);
        `CHK(irqReq[p], 1'h0)
      end
    end
    // Short random pulses with the global enable off, then with the pin A mask off
    gie <= 1'h0;
    wr(SLEIS_ADDR_CTRL, 8'h02);
    pm.lowFor(0, 2 + $urandom % 3);
    wn(5);
    `CHK(irqReq[0], 1'h0)
    rd(SLEIS_ADDR_FLAG, d);
    `CHK(d, 8'h40)
    wr(SLEIS_ADDR_FLAG, 8'h40);
    rd(SLEIS_ADDR_FLAG, d);
    `CHK(d, 8'h00)
    gie <= 1'h1;
    wr(SLEIS_ADDR_MASK, 8'h80);
    pm.lowFor(0, 2 + $urandom % 3);
    wn(5);
    `CHK(irqReq[0], 1'h0)
    wr(SLEIS_ADDR_MASK, 8'hC0);
    wn(2);
    `CHK(irqReq[0], 1'h1)
    clr();
    // Idle sleep and edge wake
    wr(SLEIS_ADDR_CTRL, 8'h02);
    slp();
    `CHK(cpuHalt, 1'h0)
    wr(SLEIS_ADDR_CTRL, 8'h22);
    slp();
    `CHK({cpuHalt, oscStop}, 2'h2)
    fork pm.lowFor(0, 3); waitEv(20, 0, got); join
    `CHK(got, 1'h1)
    `CHK(cpuHalt, 1'h0)
    clr();
    rd(SLEIS_ADDR_CTRL, d);
    `CHK(d, 8'h22)
    // Power-down: only a long low level wakes
    wr(SLEIS_ADDR_CTRL, 8'h32);
    slp();
    `CHK(oscStop, 1'h1)
    fork pm.lowFor(0, 3); waitEv(20, 0, got); join
    `CHK(got, 1'h0)
    fork pm.lowFor(1, 5); waitEv(20, 0, got); join
    `CHK(got, 1'h0)
    fork pm.lowFor(1, 30); waitEv(25, 0, got); join
    `CHK(got, 1'h1)
    `CHK(oscStop, 1'h0)
    clr();
    // Reset sources while asleep
    for (int s = 0; s < 2; s++) begin
      wr(SLEIS_ADDR_CTRL, 8'h30);
      slp();
      wdEn <= 1'h1;
      if (s == 0) fork pm.lowFor(2, 2); waitEv(15, 1, got); join
      else fork begin @(posedge clk); wdRst <= 1'h1; @(posedge clk); wdRst <= 1'h0; end waitEv(15, 1, got); join
      `CHK(got, 1'h1)
    end
    // Disabled watchdog must not wake power-down
    wr(SLEIS_ADDR_CTRL, 8'h30);
    slp();
    wdEn <= 1'h0;
    fork begin @(posedge clk); wdRst <= 1'h1; @(posedge clk); wdRst <= 1'h0; end waitEv(10, 1, got); join
    `CHK(got, 1'h0)
    `CHK(cpuHalt, 1'h1)
    rd(SLEIS_ADDR_STAT, d);
    `CHK(d, 8'h02)
    give_verdict();
  end
endmodule
